//--- include/dmsc_pkg.sv
// Shared constants and types for the dual-modulus swallow counter control
package dmsc_pkg;
  // Prescaler modulus N is two to the power of this width
  localparam int unsigned SWALLOW_W_DEF = 6;
  localparam int unsigned MAIN_W_DEF = 10;
  localparam logic MOD_HIGH = 1'b1;
  localparam logic MOD_LOW = 1'b0;
  localparam logic PULSE_RST = 1'b0;

  typedef struct packed {
    logic up;
    logic dn;
  } dmsc_pfd_t;

  localparam dmsc_pfd_t PFD_RST = '{up: 1'b0, dn: 1'b0};
endpackage : dmsc_pkg

//--- verilog/dmsc_top.sv
// Swallow and main counter control with modulus select and phase/frequency detector
// Operation
// - Swallow counter holds log2 of N bits
// - Ratio word: main high, swallow low
// - Division ratio equals N times M plus A
// - Zero phase error gives minimal up/down pulses
// - Counters clock together; cycle starts at N+1 unless A is zero
// - Swallow done switches to N until main done
// - Main done reloads both, returns to N+1 unless A is zero
`timescale 1ns/1ns
module dmsc_top #(
  parameter int unsigned SWALLOW_W = dmsc_pkg::SWALLOW_W_DEF,
  parameter int unsigned MAIN_W = dmsc_pkg::MAIN_W_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [MAIN_W+SWALLOW_W-1:0] ratio_word_i,
  input wire logic ref_pulse_i,
  output logic modulus_high_o,
  output logic div_pulse_o,
  output logic pfd_up_o,
  output logic pfd_dn_o
);


  // Ratio word fields and cycle events
  logic [MAIN_W-1:0] main_load;
  logic [SWALLOW_W-1:0] swallow_load;
  logic reload;
  logic swallow_last;

  // Main counter M, counts prescaler output cycles down to one
  logic [MAIN_W-1:0] main_cnt_q;
  logic [MAIN_W-1:0] main_cnt_d;

  // Swallow counter A, counts the N+1 periods down to zero
  logic [SWALLOW_W-1:0] swallow_cnt_q;
  logic [SWALLOW_W-1:0] swallow_cnt_d;

  // Phase of the division cycle; Gray codes along start, wide, narrow
  typedef enum logic [1:0] {
    DMSC_START = 2'b00,
    DMSC_WIDE = 2'b01,
    DMSC_NARROW = 2'b11
  } dmsc_phase_t;

  dmsc_phase_t phase_q;
  dmsc_phase_t phase_d;

  // Modulus control towards the prescaler, high selects N+1
  logic mod_q;
  logic mod_d;

  // One-cycle pulse marking the end of each division cycle
  logic div_q;
  logic div_d;

  // Two flip-flop phase/frequency detector state
  dmsc_pkg::dmsc_pfd_t pfd_q;
  dmsc_pkg::dmsc_pfd_t pfd_d;

  // Word split: swallow field is log2 N wide, the rest belongs to main.
  // Surplus upper swallow bits are not masked here; the loader keeps them zero.
  assign main_load = ratio_word_i[MAIN_W+SWALLOW_W-1:SWALLOW_W];
  assign swallow_load = ratio_word_i[SWALLOW_W-1:0];

  // Main count of one ends the cycle; zero occurs right after reset or with M of zero,
  // so the first edge after reset already loads the programmed word.
  // The word is only sampled here, so changes between reloads are ignored.
  // Limitation: M of zero or one gives a period of a single cycle.
  assign reload = (main_cnt_q <= MAIN_W'(1));

  // Swallow count at one or zero: the last N+1 period is running
  assign swallow_last = (swallow_cnt_q <= SWALLOW_W'(1));

  // Main counter: reload on completion, otherwise count down
  always_comb begin
    main_cnt_d = main_cnt_q;
    if (reload) begin
      main_cnt_d = main_load;
    end else begin
      main_cnt_d = main_cnt_q - MAIN_W'(1);
    end
  end

  // Cleared by reset so that the first edge is a reload edge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_cnt_q <= '0;
    end else begin
      main_cnt_q <= main_cnt_d;
    end
  end

  // Swallow counter: clocked with main, holds at zero once done
  always_comb begin
    swallow_cnt_d = swallow_cnt_q;
    if (reload) begin
      swallow_cnt_d = swallow_load;
    end else if (swallow_cnt_q != '0) begin
      swallow_cnt_d = swallow_cnt_q - SWALLOW_W'(1);
    end
  end

  // Swallow register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      swallow_cnt_q <= '0;
    end else begin
      swallow_cnt_q <= swallow_cnt_d;
    end
  end

  // Phase: wide while the swallow count runs, narrow until main completes.
  // A*(N+1) + (M-A)*N input cycles give the ratio N*M+A.
  always_comb begin
    phase_d = phase_q;
    if (reload) begin
      // A zero swallow value needs no N+1 periods at all
      phase_d = (swallow_load != '0) ? DMSC_WIDE : DMSC_NARROW;
    end else begin
      unique case (phase_q)
        DMSC_START: begin
          phase_d = DMSC_START;
        end
        DMSC_WIDE: begin
          if (swallow_last) begin
            phase_d = DMSC_NARROW;
          end
        end
        DMSC_NARROW: begin
          phase_d = DMSC_NARROW;
        end
        default: begin
          // Unused code 2'b10: fall back to the start phase
          phase_d = DMSC_START;
        end
      endcase
    end
  end

  // Phase register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= DMSC_START;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Modulus control: high in start and wide phases, low in narrow.
  // Reset selects N+1, as in the start phase; the first cycle starts wide only for nonzero A.
  always_comb begin
    mod_d = dmsc_pkg::MOD_HIGH;
    if (phase_d == DMSC_NARROW) begin
      mod_d = dmsc_pkg::MOD_LOW;
    end
  end

  // Modulus register, so the prescaler sees no compare glitches
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mod_q <= dmsc_pkg::MOD_HIGH;
    end else begin
      mod_q <= mod_d;
    end
  end

  // Divider pulse: one cycle per division cycle, at the reload edge
  always_comb begin
    div_d = dmsc_pkg::PULSE_RST;
    if (reload) begin
      div_d = 1'b1;
    end
  end

  // Divider pulse register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= dmsc_pkg::PULSE_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // Reference sets up, divider sets down, both high clears both, so zero
  // phase error leaves one-cycle pulses on both outputs
  always_comb begin
    pfd_d = pfd_q;
    // Mutual clear once both flip-flops are set
    if (pfd_q.up && pfd_q.dn) begin
      pfd_d = dmsc_pkg::PFD_RST;
    end
    // Set wins over the clear so a new edge is never dropped
    if (ref_pulse_i) begin
      pfd_d.up = 1'b1;
    end
    if (div_q) begin
      pfd_d.dn = 1'b1;
    end
  end

  // Detector flip-flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pfd_q <= dmsc_pkg::PFD_RST;
    end else begin
      pfd_q <= pfd_d;
    end
  end

  // Outputs come straight from the registers above
  assign modulus_high_o = mod_q;
  assign div_pulse_o = div_q;
  assign pfd_up_o = pfd_q.up;
  assign pfd_dn_o = pfd_q.dn;

endmodule : dmsc_top

//--- tb/dmsc_monitor.sv
// Port checks for the swallow counter
`timescale 1ns/1ns
module dmsc_monitor #(parameter int unsigned SWALLOW_W = 6, parameter int unsigned MAIN_W = 10) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [MAIN_W+SWALLOW_W-1:0] ratio_word_i,
  input wire logic ref_pulse_i,
  input wire logic modulus_high_o,
  input wire logic div_pulse_o,
  input wire logic pfd_up_o,
  input wire logic pfd_dn_o
);
  // Cycles since the last divider pulse; zero until the first one after reset
  logic [MAIN_W-1:0] c_q, c_d;
  wire [SWALLOW_W-1:0] a = ratio_word_i[SWALLOW_W-1:0];
  wire [MAIN_W-1:0] m = ratio_word_i[MAIN_W+SWALLOW_W-1:SWALLOW_W];
  always_comb c_d = div_pulse_o ? MAIN_W'(1) : ((c_q == '0) ? c_q : c_q + MAIN_W'(1));
  always_ff @(posedge clk_sys_i or negedge rst_b_i) if (!rst_b_i) c_q <= '0; else c_q <= c_d;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence both_once; pfd_up_o && pfd_dn_o ##1 !pfd_up_o && !pfd_dn_o; endsequence
  mod_select_a: assert property (modulus_high_o == (div_pulse_o ? a != 0 : c_q < a)) else $error("mod");
  div_period_a: assert property (c_q != 0 |-> div_pulse_o == (c_q == m)) else $error("period");
  up_set_a: assert property (ref_pulse_i |=> pfd_up_o) else $error("up");
  dn_set_a: assert property (div_pulse_o |=> pfd_dn_o) else $error("dn");
  up_hold_a: assert property (pfd_up_o && !pfd_dn_o |=> pfd_up_o) else $error("uph");
  dn_hold_a: assert property (pfd_dn_o && !pfd_up_o |=> pfd_dn_o) else $error("dnh");
  min_pulse_a: assert property (ref_pulse_i && div_pulse_o |=> both_once) else $error("min");
endmodule : dmsc_monitor
bind dmsc_top dmsc_monitor #(.SWALLOW_W(SWALLOW_W), .MAIN_W(MAIN_W)) u_mon (.*);

//--- tb/dmsc_ref_model.sv
// Reference divider, phase locked to the divider pulse
`timescale 1ns/1ns
module dmsc_ref_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic div_i,
  output logic ref_o
);
  initial ref_o = 1'b0;
  always @(negedge clk_i) ref_o <= en_i && div_i;
endmodule : dmsc_ref_model

//--- tb/tb.sv
// Bench for the swallow counter control
`timescale 1ns/1ns
module tb;
  logic clk_sys_i, rst_b_i, en, rf, md, dv, up, dn;
  int failures, checks_done, cyc;
  // M 63 above A 1, top swallow bits zero, P 4033
  localparam logic [15:0] W = 16'h0fc1;
  dmsc_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ratio_word_i(W), .ref_pulse_i(rf),
    .modulus_high_o(md), .div_pulse_o(dv), .pfd_up_o(up), .pfd_dn_o(dn));
  dmsc_ref_model ref_m (.clk_i(clk_sys_i), .en_i(en), .div_i(dv), .ref_o(rf));
  initial begin clk_sys_i = 0; forever #50 clk_sys_i = ~clk_sys_i; end
  always @(posedge clk_sys_i) if (++cyc > 3000) begin failures++; conclude(); end
  task automatic chk(input string n, input logic s, e);
    checks_done++;
    if (s !== e) begin failures++; $display("[ERR] %s exp %b got %b", n, e, s); end
  endtask : chk
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic t_cycle();
    for (int i = 0; i < 99 && dv !== 1'b1; i++) @(negedge clk_sys_i);
    for (int k = 0; k < 126; k++) begin
      chk("div", dv, k % 63 == 0);
      chk("mod", md, k % 63 < 1);
      @(negedge clk_sys_i);
    end
    $display("cycle done");
  endtask : t_cycle
  task automatic t_pfd();
    en = 1;
    repeat (64) @(negedge clk_sys_i);
    for (int i = 0; i < 70 && dv !== 1'b1; i++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("up_set", up, 1);
    chk("dn_set", dn, 1);
    @(negedge clk_sys_i);
    chk("up_clr", up, 0);
    chk("dn_clr", dn, 0);
    repeat (130) begin @(negedge clk_sys_i); chk("pair", up, dn); end
    en = 0;
    repeat (70) @(negedge clk_sys_i);
    chk("dn", dn, 1);
    chk("up", up, 0);
    $display("pfd done");
  endtask : t_pfd
  initial begin
    rst_b_i = 0; en = 0; cyc = 0; failures = 0; checks_done = 0;
    repeat (16) @(negedge clk_sys_i);
    rst_b_i = 1;
    t_cycle(); t_pfd(); conclude();
  end
endmodule : tb
